// ==== rtl/jtag_tda_pkg.sv ====
package jtag_tda_pkg;

   // -------------------------------------------------------------
   // Register bus and register map.
   // -------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam logic [APB_AW-1:0] OFS_ERASE_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] OFS_STATUS_CLR = 8'h04;
   localparam logic [APB_AW-1:0] OFS_STATUS = 8'h08;

   // Field positions of erase_control_word.
   localparam int BIT_CE = 0;
   localparam int BIT_BUSY = 1;

   // Field positions shared by status_word and status_clear_register.
   localparam int ST_DONE = 0;
   localparam int ST_HOLD = 1;
   localparam int ST_JTAG_EN = 2;
   localparam int ST_PROT = 3;

   // Reset values of the control state.
   localparam logic RST_PROT = 1'h1;
   localparam logic RST_HOLD = 1'h0;
   localparam logic RST_DONE = 1'h0;

   // -------------------------------------------------------------
   // Instruction register.
   // -------------------------------------------------------------
   localparam int IR_W = 4;
   localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
   localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
   localparam logic [IR_W-1:0] IR_SAMPLE = 4'h2;
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   localparam int ID_W = 32;

   // -------------------------------------------------------------
   // Positions in the synchroniser vector.
   // -------------------------------------------------------------
   localparam int IX_RST = 0;
   localparam int IX_TCK = 1;
   localparam int IX_TMS = 2;
   localparam int IX_TDI = 3;
   localparam int IX_PIN0 = 4;

   // -------------------------------------------------------------
   // State encodings.
   // -------------------------------------------------------------
   typedef enum logic [3:0] {
      TLR = 4'h0,
      RTI = 4'h1,
      SEL_DR = 4'h2,
      CAP_DR = 4'h3,
      SH_DR = 4'h4,
      EX1_DR = 4'h5,
      PA_DR = 4'h6,
      EX2_DR = 4'h7,
      UP_DR = 4'h8,
      SEL_IR = 4'h9,
      CAP_IR = 4'hA,
      SH_IR = 4'hB,
      EX1_IR = 4'hC,
      PA_IR = 4'hD,
      EX2_IR = 4'hE,
      UP_IR = 4'hF
   } tap_t;

   typedef enum logic [1:0] {
      E_IDLE = 2'h0,
      E_VOL = 2'h1,
      E_FLASH = 2'h2,
      E_PROT = 2'h3
   } erase_t;

endpackage

// ==== rtl/jtag_test_debug_access.sv ====
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module jtag_test_debug_access #(
   parameter int N_PINS = 8,
   parameter int ERASE_STEP_CYC = 16,
   // Arbitrary neutral identification word; bit zero must be one.
   parameter logic [31:0] IDCODE_VALUE = 32'h0000_1001
) (
   // Clock, reset and clock enable.
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // External reset pin and test access pins.
   input wire logic i_rst_n,
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   output logic o_tdo,
   output logic o_tdo_oe,
   output logic o_jtag_en,
   // Device pins and the core logic behind them.
   input wire logic [N_PINS-1:0] i_pin_in,
   input wire logic [N_PINS-1:0] i_core_out,
   input wire logic [N_PINS-1:0] i_core_oe,
   output logic [N_PINS-1:0] o_pin_out,
   output logic [N_PINS-1:0] o_pin_oe,
   // Core hold, protection and system bus access.
   input wire logic i_prot_fuse,
   output logic o_core_hold,
   output logic o_protected,
   output logic o_sba_en,
   output logic o_pagebuf_wr_en,
   // Chip erase steps.
   output logic o_erase_volatile,
   output logic o_erase_flash,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [jtag_tda_pkg::APB_AW-1:0] i_paddr,
   input wire logic [jtag_tda_pkg::APB_DW-1:0] i_pwdata,
   output logic [jtag_tda_pkg::APB_DW-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);
   import jtag_tda_pkg::*;

   // -------------------------------------------------------------
   // Parameter checks.
   // -------------------------------------------------------------
   localparam int SW = N_PINS + IX_PIN0;
   localparam int CW = $clog2(ERASE_STEP_CYC + 1);
   localparam logic [CW-1:0] STEP_LOAD = CW'(ERASE_STEP_CYC - 1);

   // The boundary shift needs two cells, and an ID word must end in one.
   if (N_PINS < 2 || ERASE_STEP_CYC < 1 || IDCODE_VALUE[0] != 1'h1) begin : g_bad
      $error("jtag_test_debug_access: unsupported parameter value");
   end

   // -------------------------------------------------------------
   // Pin synchronisers and edge detection.
   // -------------------------------------------------------------
   logic [SW-1:0] s1_q;
   logic [SW-1:0] s2_q;
   logic tck_prev_q;
   logic rstn_prev_q;
   wire [SW-1:0] pin_raw = {i_pin_in, i_tdi, i_tms, i_tck, i_rst_n};

   // Only the second stage is looked at; the first may be metastable.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         tck_prev_q <= 1'h0;
         rstn_prev_q <= 1'h0;
      end else if (i_clk_en) begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         tck_prev_q <= s2_q[IX_TCK];
         rstn_prev_q <= s2_q[IX_RST];
      end
   end

   // Edges of TCK and the release of the external reset.
   wire rstn_s = s2_q[IX_RST];
   wire tck_s = s2_q[IX_TCK];
   wire tms_s = s2_q[IX_TMS];
   wire tdi_s = s2_q[IX_TDI];
   wire [N_PINS-1:0] pins_s = s2_q[SW-1:IX_PIN0];
   wire tck_rise = tck_s & ~tck_prev_q;
   wire tck_fall = ~tck_s & tck_prev_q;
   wire rst_rel = rstn_s & ~rstn_prev_q;

   // -------------------------------------------------------------
   // APB slave.
   // -------------------------------------------------------------
   logic prot_q;
   logic hold_q;
   logic done_q;
   logic jtag_en_q;
   logic armed_q;
   erase_t er_q;
   logic [APB_DW-1:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // Decode; every access completes with one access cycle.
   wire setup = i_psel & ~i_penable;
   wire wr = i_psel & i_penable & pready_q & i_pwrite;
   wire hit_ctrl = i_paddr == OFS_ERASE_CTRL;
   wire hit_clr = i_paddr == OFS_STATUS_CLR;
   wire hit_stat = i_paddr == OFS_STATUS;
   wire mapped = hit_ctrl | hit_clr | hit_stat;
   wire ce_wr = wr & hit_ctrl & i_pwdata[BIT_CE];
   wire clr_done = wr & hit_clr & i_pwdata[ST_DONE];
   wire clr_hold = wr & hit_clr & i_pwdata[ST_HOLD] & ~prot_q;

   // Read views; the trigger bit itself always reads zero.
   wire er_busy = er_q != E_IDLE;
   wire [APB_DW-1:0] ctrl_v = APB_DW'(er_busy) << BIT_BUSY;
   wire [APB_DW-1:0] stat_v = (APB_DW'(done_q) << ST_DONE)
                            | (APB_DW'(hold_q) << ST_HOLD)
                            | (APB_DW'(jtag_en_q) << ST_JTAG_EN)
                            | (APB_DW'(prot_q) << ST_PROT);
   wire [APB_DW-1:0] rdata_d = hit_stat ? stat_v : (hit_ctrl ? ctrl_v : '0);

   // Answer is prepared in the setup cycle so pready is a flop.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         prdata_q <= '0;
         pready_q <= 1'h0;
         pslverr_q <= 1'h0;
      end else if (i_clk_en) begin
         pready_q <= setup;
         pslverr_q <= setup & ~mapped;
         if (setup) begin
            prdata_q <= rdata_d;
         end
      end
   end

   // -------------------------------------------------------------
   // Pin enable and core hold.
   // -------------------------------------------------------------
   // Enabling is armed only when TCK is low as the reset releases.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         jtag_en_q <= 1'h0;
         armed_q <= 1'h0;
      end else if (i_clk_en) begin
         if (!rstn_s) begin
            jtag_en_q <= 1'h0;
            armed_q <= 1'h0;
         end else if (rst_rel) begin
            armed_q <= ~tck_s;
         end else if (armed_q && tck_fall) begin
            jtag_en_q <= 1'h1;
         end
      end
   end

   // The release event wins over a clear written in the same cycle.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         hold_q <= RST_HOLD;
      end else if (i_clk_en) begin
         if (rst_rel) begin
            hold_q <= ~tck_s;
         end else if (clr_hold) begin
            hold_q <= 1'h0;
         end
      end
   end

   // -------------------------------------------------------------
   // Chip erase sequencer.
   // -------------------------------------------------------------
   logic [CW-1:0] ecnt_q;
   logic vol_q;
   logic fl_q;

   function automatic erase_t er_step(input erase_t s);
      erase_t n;
      n = s;
      unique case (s)
         E_IDLE: n = E_IDLE;
         E_VOL: n = E_FLASH;
         E_FLASH: n = E_PROT;
         E_PROT: n = E_IDLE;
      endcase
      return n;
   endfunction

   // A trigger while an erase runs is ignored.
   wire er_adv = er_busy & (ecnt_q == '0);
   wire er_fin = (er_q == E_PROT) & er_adv;
   wire er_start = ~er_busy & ce_wr;
   wire erase_t er_d = er_start ? E_VOL : (er_adv ? er_step(er_q) : er_q);

   // Each step lasts a fixed number of clock cycles.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         er_q <= E_IDLE;
         ecnt_q <= '0;
         vol_q <= 1'h0;
         fl_q <= 1'h0;
      end else if (i_clk_en) begin
         er_q <= er_d;
         ecnt_q <= (er_start || er_adv) ? STEP_LOAD : (er_busy ? ecnt_q - 1'h1 : ecnt_q);
         vol_q <= er_d == E_VOL;
         fl_q <= er_d == E_FLASH;
      end
   end

   // Completion wins over a clear that lands in the same cycle.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         done_q <= RST_DONE;
      end else if (i_clk_en) begin
         if (er_fin) begin
            done_q <= 1'h1;
         end else if (er_start || clr_done) begin
            done_q <= 1'h0;
         end
      end
   end

   // The stored protection is taken up only at a chip reset release.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         prot_q <= RST_PROT;
      end else if (i_clk_en) begin
         if (rst_rel) begin
            prot_q <= i_prot_fuse;
         end else if (er_fin) begin
            prot_q <= 1'h0;
         end
      end
   end

   // -------------------------------------------------------------
   // TAP controller.
   // -------------------------------------------------------------
   tap_t tap_q;

   function automatic tap_t tap_next(input tap_t s, input logic tms);
      tap_t n;
      n = s;
      unique case (s)
         TLR: n = tms ? TLR : RTI;
         RTI: n = tms ? SEL_DR : RTI;
         SEL_DR: n = tms ? SEL_IR : CAP_DR;
         CAP_DR: n = tms ? EX1_DR : SH_DR;
         SH_DR: n = tms ? EX1_DR : SH_DR;
         EX1_DR: n = tms ? UP_DR : PA_DR;
         PA_DR: n = tms ? EX2_DR : PA_DR;
         EX2_DR: n = tms ? UP_DR : SH_DR;
         UP_DR: n = tms ? SEL_DR : RTI;
         SEL_IR: n = tms ? TLR : CAP_IR;
         CAP_IR: n = tms ? EX1_IR : SH_IR;
         SH_IR: n = tms ? EX1_IR : SH_IR;
         EX1_IR: n = tms ? UP_IR : PA_IR;
         PA_IR: n = tms ? EX2_IR : PA_IR;
         EX2_IR: n = tms ? UP_IR : SH_IR;
         UP_IR: n = tms ? SEL_DR : RTI;
      endcase
      return n;
   endfunction

   // Scan state moves only on rising TCK edges, or back to TLR once the pins are disabled; no other clock matters.
   wire tap_go = jtag_en_q & tck_rise;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         tap_q <= TLR;
      end else if (i_clk_en) begin
         if (!jtag_en_q) begin
            tap_q <= TLR;
         end else if (tap_go) begin
            tap_q <= tap_next(tap_q, tms_s);
         end
      end
   end

   // -------------------------------------------------------------
   // Instruction and data registers.
   // -------------------------------------------------------------
   logic [IR_W-1:0] ir_sh_q;
   logic [IR_W-1:0] ir_q;
   logic byp_q;
   logic [ID_W-1:0] id_sh_q;
   logic [N_PINS-1:0] bsr_sh_q;
   logic [N_PINS-1:0] bsr_upd_q;

   // Unknown codes fall back to the one-bit bypass path.
   wire sel_id = ir_q == IR_IDCODE;
   wire sel_bsr = (ir_q == IR_SAMPLE) | (ir_q == IR_EXTEST);
   wire sel_byp = ~sel_id & ~sel_bsr;
   wire extest = jtag_en_q & (ir_q == IR_EXTEST);
   wire upd_ir = jtag_en_q & tck_fall & (tap_q == UP_IR);
   wire upd_dr = jtag_en_q & tck_fall & (tap_q == UP_DR);

   // Instruction shift path and its latched output.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ir_sh_q <= IR_CAPTURE;
         ir_q <= IR_IDCODE;
      end else if (i_clk_en) begin
         if (tap_go && tap_q == CAP_IR) begin
            ir_sh_q <= IR_CAPTURE;
         end else if (tap_go && tap_q == SH_IR) begin
            ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
         end
         if (!jtag_en_q || tap_q == TLR) begin
            ir_q <= IR_IDCODE;
         end else if (upd_ir) begin
            ir_q <= ir_sh_q;
         end
      end
   end

   // Capture loads every data register; only the selected one shifts.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         byp_q <= 1'h0;
         id_sh_q <= '0;
         bsr_sh_q <= '0;
      end else if (i_clk_en && tap_go) begin
         if (tap_q == CAP_DR) begin
            byp_q <= 1'h0;
            id_sh_q <= IDCODE_VALUE;
            bsr_sh_q <= pins_s;
         end else if (tap_q == SH_DR) begin
            if (sel_byp) begin
               byp_q <= tdi_s;
            end
            if (sel_id) begin
               id_sh_q <= {tdi_s, id_sh_q[ID_W-1:1]};
            end
            if (sel_bsr) begin
               bsr_sh_q <= {tdi_s, bsr_sh_q[N_PINS-1:1]};
            end
         end
      end
   end

   // Preloaded values are held here until EXTEST puts them out.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         bsr_upd_q <= '0;
      end else if (i_clk_en && upd_dr && sel_bsr) begin
         bsr_upd_q <= bsr_sh_q;
      end
   end

   // -------------------------------------------------------------
   // TDO driver.
   // -------------------------------------------------------------
   logic tdo_q;
   logic tdo_oe_q;
   wire in_shift = (tap_q == SH_IR) | (tap_q == SH_DR);
   wire tdo_bit = (tap_q == SH_IR) ? ir_sh_q[0]
                : (sel_id ? id_sh_q[0] : (sel_bsr ? bsr_sh_q[0] : byp_q));

   // Changing TDO on the falling edge gives the far end half a period.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         tdo_q <= 1'h0;
         tdo_oe_q <= 1'h0;
      end else if (i_clk_en) begin
         // The external reset also drops the driver at once, so TDO never
         // stays driven after the pins are disabled.
         if (!jtag_en_q || !rstn_s) begin
            tdo_oe_q <= 1'h0;
         end else if (tck_fall) begin
            tdo_q <= tdo_bit;
            tdo_oe_q <= in_shift;
         end
      end
   end

   // -------------------------------------------------------------
   // Port pin multiplexers.
   // -------------------------------------------------------------
   logic [N_PINS-1:0] pin_out_d;
   logic [N_PINS-1:0] pin_oe_d;
   logic [N_PINS-1:0] pin_out_q;
   logic [N_PINS-1:0] pin_oe_q;

   // A device reset clears the pin enable, which ends EXTEST, so every pin driver turns off in it.
   for (genvar i = 0; i < N_PINS; i++) begin : g_pin
      assign pin_out_d[i] = extest ? bsr_upd_q[i] : i_core_out[i];
      assign pin_oe_d[i] = extest | (rstn_s & i_core_oe[i]);
   end

   // Status outputs and pin drivers, all registered.
   logic sba_en_q;
   logic pagebuf_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         pin_out_q <= '0;
         pin_oe_q <= '0;
         sba_en_q <= 1'h0;
         pagebuf_q <= 1'h0;
      end else if (i_clk_en) begin
         pin_out_q <= pin_out_d;
         pin_oe_q <= pin_oe_d;
         sba_en_q <= ~prot_q;
         pagebuf_q <= ~prot_q & ~hold_q;
      end
   end

   // -------------------------------------------------------------
   // Outputs.
   // -------------------------------------------------------------
   assign o_tdo = tdo_q;
   assign o_tdo_oe = tdo_oe_q;
   assign o_jtag_en = jtag_en_q;
   assign o_pin_out = pin_out_q;
   assign o_pin_oe = pin_oe_q;
   assign o_core_hold = hold_q;
   assign o_protected = prot_q;
   assign o_sba_en = sba_en_q;
   assign o_pagebuf_wr_en = pagebuf_q;
   assign o_erase_volatile = vol_q;
   assign o_erase_flash = fl_q;
   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;

endmodule

// ==== dv/jtag_tda_assertions.sv ====
`timescale 1ns/1ps
module jtag_tda_assertions #(
   parameter int ERASE_STEP_CYC = 16
) (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // Register bus.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [jtag_tda_pkg::APB_AW-1:0] i_paddr,
   input wire logic [jtag_tda_pkg::APB_DW-1:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // Test port, protection and erase.
   input wire logic o_tdo_oe,
   input wire logic o_jtag_en,
   input wire logic o_protected,
   input wire logic o_core_hold,
   input wire logic o_sba_en,
   input wire logic o_pagebuf_wr_en,
   input wire logic o_erase_volatile,
   input wire logic o_erase_flash
);
   import jtag_tda_pkg::*;
   // The protection step lasts one step count; a few cycles of slack cover the pipeline.
   localparam int PROT_WIN = ERASE_STEP_CYC + 4;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);
   // Only three word offsets are decoded, so anything else must be refused.
   wire logic mapped;
   assign mapped = (i_paddr == OFS_ERASE_CTRL) || (i_paddr == OFS_STATUS_CLR) ||
      (i_paddr == OFS_STATUS);
   // ---------------------------------------------------------------
   // Register bus.
   // ---------------------------------------------------------------
   a_pready_setup: assert property (i_psel && !i_penable && i_clk_en |=> o_pready)
      else $error("No ready after setup.");
   a_pready_once: assert property (o_pready && i_clk_en |=> !o_pready)
      else $error("Ready held too long.");
   a_err_decode: assert property (o_pready |-> o_pslverr == !mapped)
      else $error("Error flag does not match decode.");
   a_prdata_hold: assert property ($changed(o_prdata) |-> $past(i_psel) && !$past(i_penable))
      else $error("Read data moved outside setup.");
   // ---------------------------------------------------------------
   // Access control, erase and test port.
   // ---------------------------------------------------------------
   a_sba_prot: assert property (o_sba_en == !$past(o_protected))
      else $error("Bus access does not follow protection.");
   a_pagebuf_hold: assert property (o_pagebuf_wr_en |->
      !$past(o_core_hold) && !$past(o_protected))
      else $error("Page buffer open while held or protected.");
   a_erase_order: assert property ($fell(o_erase_volatile) |-> o_erase_flash)
      else $error("Flash step does not follow volatile step.");
   a_prot_clear: assert property ($fell(o_erase_flash) |-> ##[1:PROT_WIN] !o_protected)
      else $error("Protection not cleared after erase.");
   a_tdo_enabled: assert property (o_tdo_oe |-> o_jtag_en)
      else $error("Test output driven while disabled.");
endmodule

// ==== dv/jtag_debugger_model.sv ====
`timescale 1ns/1ps
module jtag_debugger_model (
   // Pacing clock.
   input wire logic i_ref_clk,
   // Pins towards the device.
   output logic o_rst_n,
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   // Test data from the device.
   input wire logic i_tdo
);
   logic dummy;
   // The link starts in reset with the clock high, so nothing is armed.
   initial begin
      o_rst_n = 1'b0;
      o_tck = 1'b1;
      o_tms = 1'b1;
      o_tdi = 1'b0;
   end
   // TMS and TDI settle two cycles before the rise, so the synchroniser never sees a race.
   task automatic tick(input logic ms, input logic di, output logic so);
      o_tms <= ms;
      o_tdi <= di;
      repeat (2) @(posedge i_ref_clk);
      so = i_tdo;
      o_tck <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      o_tck <= 1'b0;
      o_tdi <= ~di;
      repeat (2) @(posedge i_ref_clk);
   endtask
   task automatic scan(input logic [31:0] din, input int n, output logic [31:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], dout[i]);
      end
      tick(1'b1, 1'b0, dummy);
      tick(1'b0, 1'b0, dummy);
   endtask
   task automatic tlr();
      repeat (5) tick(1'b1, 1'b0, dummy);
      tick(1'b0, 1'b0, dummy);
   endtask
   task automatic ir(input logic [3:0] code, output logic [31:0] cap);
      repeat (2) tick(1'b1, 1'b0, dummy);
      repeat (2) tick(1'b0, 1'b0, dummy);
      scan({28'h0, code}, 4, cap);
   endtask
   task automatic dr(input logic [31:0] din, input int n, output logic [31:0] dout);
      tick(1'b1, 1'b0, dummy);
      repeat (2) tick(1'b0, 1'b0, dummy);
      scan(din, n, dout);
   endtask
   task automatic enter_rst(input logic lvl);
      o_rst_n <= 1'b0;
      o_tck <= lvl;
      repeat (8) @(posedge i_ref_clk);
   endtask
   task automatic leave_rst();
      o_rst_n <= 1'b1;
      repeat (8) @(posedge i_ref_clk);
   endtask
   task automatic wake();
      o_tck <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      o_tck <= 1'b0;
      repeat (8) @(posedge i_ref_clk);
   endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import jtag_tda_pkg::*;
   localparam int STEP = 4;
   // Arbitrary identification word; bit zero is set as the format needs.
   localparam logic [31:0] ID = 32'h0000_2A03;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rst_n, tck, tms, tdi, tdo, tdo_pin, tdo_oe, jtag_en, fuse, hold, prot, sba, pbw;
   logic psel, penable, pwrite, pready, pslverr, rerr, evol, efl;
   logic [7:0] pin_in, core_out, core_oe, pin_out, pin_oe, paddr;
   logic [31:0] pwdata, prdata, rdat, got, cap;
   int failures = 0;
   int check_count = 0;
   jtag_test_debug_access #(.N_PINS(8), .ERASE_STEP_CYC(STEP), .IDCODE_VALUE(ID)) i_dut (
      .i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_rst_n(rst_n), .i_tck(tck),
      .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_jtag_en(jtag_en),
      .i_pin_in(pin_in), .i_core_out(core_out), .i_core_oe(core_oe), .o_pin_out(pin_out),
      .o_pin_oe(pin_oe), .i_prot_fuse(fuse), .o_core_hold(hold), .o_protected(prot),
      .o_sba_en(sba), .o_pagebuf_wr_en(pbw), .o_erase_volatile(evol), .o_erase_flash(efl),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
   // TDO has a pull-up, so a released line reads high.
   assign tdo_pin = tdo_oe ? tdo : 1'b1;
   jtag_debugger_model u_dbg (.i_ref_clk(clk), .o_rst_n(rst_n), .o_tck(tck), .o_tms(tms),
      .o_tdi(tdi), .i_tdo(tdo_pin));
   always #50 clk = ~clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, g, e);
      end
   endtask
   // The master waits as long as the slave takes; only the watchdog ends a hang.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      chk(n, 1, "bus answer");
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, '0);
      chk(rdat, e, "read");
   endtask
   task automatic t_disabled();
      u_dbg.enter_rst(1'b1);
      chk(pin_oe, 0, "pins in reset");
      u_dbg.leave_rst();
      u_dbg.wake();
      u_dbg.tlr();
      u_dbg.dr('1, 32, got);
      chk(jtag_en, 0, "disabled");
      rd(OFS_STATUS, 32'h0);
      $display("t_disabled done");
   endtask
   task automatic t_hold();
      u_dbg.enter_rst(1'b0);
      u_dbg.leave_rst();
      chk(hold, 1, "hold");
      chk(jtag_en, 0, "before fall");
      u_dbg.wake();
      chk(jtag_en, 1, "enabled");
      rd(OFS_STATUS, 32'h6);
      chk(pbw, 0, "page buffer");
      chk(sba, 1, "bus access");
      apb(1'b1, OFS_STATUS_CLR, 32'h0);
      rd(OFS_STATUS, 32'h6);
      apb(1'b1, OFS_STATUS_CLR, 32'h2);
      rd(OFS_STATUS, 32'h4);
      chk(pbw, 1, "page buffer");
      rd(8'h0C, 32'h0);
      chk(rerr, 1, "unmapped");
      $display("t_hold done");
   endtask
   task automatic t_scan();
      u_dbg.tlr();
      u_dbg.dr('1, 32, got);
      chk(got, ID, "idcode");
      u_dbg.ir(IR_BYPASS, cap);
      chk(cap, {28'h0, IR_CAPTURE}, "ir capture");
      u_dbg.dr(32'h5, 3, got);
      chk(got, 32'h2, "bypass");
      $display("t_scan done");
   endtask
   task automatic t_boundary();
      u_dbg.ir(IR_SAMPLE, cap);
      u_dbg.dr(32'h96, 8, got);
      chk(got, 32'hA5, "sample");
      chk(pin_out, 8'h3C, "undisturbed");
      u_dbg.ir(IR_EXTEST, cap);
      chk(pin_out, 8'h96, "extest");
      u_dbg.dr(32'h0F, 8, got);
      chk(got, 32'hA5, "extest sample");
      chk(pin_out, 8'h0F, "update");
      u_dbg.tlr();
      chk(pin_out, 8'h3C, "normal pins");
      $display("t_boundary done");
   endtask
   task automatic t_erase();
      fuse <= 1'b1;
      @(posedge clk);
      chk(prot, 0, "not yet");
      u_dbg.enter_rst(1'b0);
      u_dbg.leave_rst();
      chk(prot, 1, "protected");
      chk(sba, 0, "bus access");
      apb(1'b1, OFS_STATUS_CLR, 32'h2);
      chk(hold, 1, "hold kept");
      apb(1'b1, OFS_ERASE_CTRL, 32'h1);
      chk(evol, 1, "volatile step");
      chk(efl, 0, "flash waits");
      rd(OFS_ERASE_CTRL, 32'h2);
      rd(OFS_STATUS, 32'hA);
      chk(efl, 1, "flash step");
      chk(evol, 0, "volatile done");
      repeat (3 * STEP) @(posedge clk);
      rd(OFS_STATUS, 32'h3);
      chk(efl, 0, "flash done");
      chk(prot, 0, "unprotected");
      apb(1'b1, OFS_STATUS_CLR, 32'h1);
      rd(OFS_STATUS, 32'h2);
      $display("t_erase done");
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Main sequence: inputs get values at time zero, then reset for 16 cycles.
   initial begin
      fuse = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pin_in = 8'hA5;
      core_out = 8'h3C;
      core_oe = 8'hFF;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(prot, 1, "reset protection");
      t_disabled();
      t_hold();
      t_scan();
      t_boundary();
      t_erase();
      end_sim();
   end
   // The tests need well under half a millisecond; this bound cuts a hang short.
   initial begin
      #2_000_000;
      failures++;
      end_sim();
   end
endmodule
bind jtag_test_debug_access jtag_tda_assertions #(.ERASE_STEP_CYC(ERASE_STEP_CYC)) u_chk (
   .i_ref_clk, .i_sys_rst, .i_clk_en, .i_psel, .i_penable, .i_paddr, .o_prdata, .o_pready,
   .o_pslverr, .o_tdo_oe, .o_jtag_en, .o_protected, .o_core_hold, .o_sba_en,
   .o_pagebuf_wr_en, .o_erase_volatile, .o_erase_flash);
